// ---- logic/ises_mem.sv ----
// Purpose: memory array with one write port and a registered read port
// Assumes: single clock, write and read addresses independent
// Notes: contents start erased; reset does not touch the array
`timescale 1ns/100ps
module ises_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 13,
  parameter logic [DATA_W-1:0] INIT_VAL = 8'hff
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData_ff
);

  logic [DATA_W-1:0] cells [2**ADDR_W];

  // delivered state: every byte erased
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      cells[i] = INIT_VAL;
    end
  end

  always_ff @(posedge clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    rdData_ff <= cells[rdAddr];
  end

endmodule : ises_mem

// ---- logic/ises_pkg.sv ----
// Purpose: shared constants and types of the serial eeprom slave
// Assumes: system clock of 100 MHz, bus pins sampled on a link clock
// Notes: time figures are kept in their own unit, cycles derived here
package ises_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int CNT_W = 20;

  // slave address byte layout
  localparam logic [3:0] DEV_PREFIX = 4'ha;
  localparam int PREFIX_HI = 7;
  localparam int PREFIX_LO = 4;
  localparam int STRAP_HI = 3;
  localparam int STRAP_LO = 1;
  localparam int RW_BIT = 0;
  localparam int ADRHI_USED = 5;

  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;
  localparam logic SDA_DRIVE_LVL = 1'b0;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int INTERNAL_PROGRAM_TIME_US = 5000;
  localparam int SUPPLY_TO_READY_DELAY_US = 1000;
  localparam int INTERNAL_PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_US * CLK_MHZ;
  localparam int SUPPLY_TO_READY_CYCLES = SUPPLY_TO_READY_DELAY_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_ADRHI = 3'h3,
    ST_ADRLO = 3'h2,
    ST_WDATA = 3'h6,
    ST_RDATA = 3'h7
  } ises_state_t;

endpackage : ises_pkg

// ---- logic/ises_top.sv ----
// Purpose: two-wire serial eeprom slave, protocol engine and write timer
// Assumes: linkClk oversamples scl and sda; resetn is the power-on reset
// Notes: sdaOut is always low, sdaOe high means the pin is pulled low
`timescale 1ns/100ps
module ises_top
  import ises_pkg::*;
#(
  parameter int PROG_CYCLES = ises_pkg::INTERNAL_PROGRAM_CYCLES,
  parameter int READY_CYCLES = ises_pkg::SUPPLY_TO_READY_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic strapSelBit0,
  input wire logic strapSelBit1,
  input wire logic strapSelBit2,
  input wire logic writeProtect,
  output logic writeCycleBusy
);

  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
  localparam logic [CNT_W-1:0] READY_LAST = CNT_W'(READY_CYCLES - 1);
  localparam logic [PAGE_W-1:0] PAGE_END = PAGE_W'(PAGE_BYTES - 1);

  // ==========================================================
  // system clock domain: power-up delay and program timer
  logic [CNT_W-1:0] puCount_ff;
  logic puRdy_ff;
  logic [CNT_W-1:0] progCount_ff;
  logic progRun_ff;
  logic progDoneT_ff;
  logic reqS1_ff, reqS2_ff, reqD_ff;
  logic progReqT_ff;
  logic progEdge;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      puCount_ff <= '0;
      puRdy_ff <= 1'b0;
    end else if (!puRdy_ff) begin
      puCount_ff <= puCount_ff + CNT_W'(1);
      puRdy_ff <= (puCount_ff == READY_LAST);
    end
  end

  always_ff @(posedge clk) begin
    reqS1_ff <= progReqT_ff;
    reqS2_ff <= reqS1_ff;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reqD_ff <= 1'b0;
    end else begin
      reqD_ff <= reqS2_ff;
    end
  end

  assign progEdge = reqS2_ff ^ reqD_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      progRun_ff <= 1'b0;
      progCount_ff <= '0;
      progDoneT_ff <= 1'b0;
    end else if (progEdge) begin
      progRun_ff <= 1'b1;
      progCount_ff <= '0;
    end else if (progRun_ff) begin
      progCount_ff <= progCount_ff + CNT_W'(1);
      if (progCount_ff == PROG_LAST) begin
        progRun_ff <= 1'b0;
        progDoneT_ff <= ~progDoneT_ff;
      end
    end
  end

  assign writeCycleBusy = progRun_ff;

  prog_time_a: assert property (@(posedge clk) disable iff (!resetn)
    progEdge |=> progRun_ff && progCount_ff == '0)
    else $error("program timer did not start");

  ready_delay_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(puRdy_ff) |-> $past(puCount_ff) == READY_LAST)
    else $error("ready flag rose at wrong count");

  // ==========================================================
  // link domain: reset and pin synchronisers
  logic rstS1_ff, rstS2_ff;
  logic linkRstn;
  logic [7:0] sync1_ff, sync2_ff;
  logic sclD_ff, sdaD_ff;
  logic sclS, sdaS, wpS, puRdyS, doneS;
  logic [2:0] strapS;

  always_ff @(posedge linkClk) begin
    rstS1_ff <= resetn;
    rstS2_ff <= rstS1_ff;
    sync1_ff <= {puRdy_ff, progDoneT_ff, strapSelBit2, strapSelBit1,
                 strapSelBit0, writeProtect, scl, sdaIn};
    sync2_ff <= sync1_ff;
  end

  assign linkRstn = rstS2_ff;
  assign {puRdyS, doneS, strapS, wpS, sclS, sdaS} = sync2_ff;

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      sclD_ff <= 1'b1;
      sdaD_ff <= 1'b1;
    end else begin
      sclD_ff <= sclS;
      sdaD_ff <= sdaS;
    end
  end

  logic sclRise, sclFall, startDet, stopDet;
  assign sclRise = sclS && !sclD_ff;
  assign sclFall = !sclS && sclD_ff;
  assign startDet = sclS && sclD_ff && sdaD_ff && !sdaS;
  assign stopDet = sclS && sclD_ff && !sdaD_ff && sdaS;

  // ==========================================================
  // link domain: byte engine
  ises_state_t state_ff, nxt_state;
  logic [3:0] bitCnt_ff;
  logic ackPhase_ff;
  logic [BYTE_W-1:0] rxShift_ff;
  logic [BYTE_W-1:0] txShift_ff;
  logic mAck_ff, txActive_ff, firstData_ff, wpLatched_ff, sdaOe_ff;
  logic [ADRHI_USED-1:0] adrHi_ff;
  logic [ADDR_W-1:0] curAddr_ff;
  logic pending_ff, commitBusy_ff;
  logic [PAGE_W-1:0] commitIdx_ff;
  logic byteEnd, ackEnd, ackRise, devAck, addrMatch, linkBusy, linkReady;
  logic [BYTE_W-1:0] rdData;

  assign linkBusy = (progReqT_ff != doneS) || commitBusy_ff;
  assign linkReady = puRdyS && !linkBusy;
  assign byteEnd = sclFall && !ackPhase_ff && (bitCnt_ff == BIT_LAST);
  assign ackEnd = sclFall && ackPhase_ff;
  assign ackRise = sclRise && ackPhase_ff;

  always_comb begin
    addrMatch = (rxShift_ff[PREFIX_HI:PREFIX_LO] == DEV_PREFIX) &&
                (rxShift_ff[STRAP_HI:STRAP_LO] == strapS);
    devAck = 1'b0;
    nxt_state = ST_IDLE;
    case (state_ff)
      ST_DEVADDR: begin
        devAck = addrMatch && linkReady;
        if (devAck) begin
          nxt_state = rxShift_ff[RW_BIT] ? ST_RDATA : ST_ADRHI;
        end
      end
      ST_ADRHI: begin
        devAck = 1'b1;
        nxt_state = ST_ADRLO;
      end
      ST_ADRLO: begin
        devAck = 1'b1;
        nxt_state = ST_WDATA;
      end
      ST_WDATA: begin
        devAck = !wpLatched_ff;
        nxt_state = wpLatched_ff ? ST_IDLE : ST_WDATA;
      end
      ST_RDATA: begin
        nxt_state = ST_RDATA;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= '0;
      ackPhase_ff <= 1'b0;
      rxShift_ff <= '0;
      mAck_ff <= 1'b0;
    end else if (startDet) begin
      state_ff <= ST_DEVADDR;
      bitCnt_ff <= '0;
      ackPhase_ff <= 1'b0;
    end else if (stopDet) begin
      state_ff <= ST_IDLE;
      ackPhase_ff <= 1'b0;
    end else if (state_ff != ST_IDLE) begin
      if (ackRise) begin
        mAck_ff <= !sdaS;
      end else if (sclRise) begin
        rxShift_ff <= {rxShift_ff[BYTE_W-2:0], sdaS};
        bitCnt_ff <= bitCnt_ff + 4'h1;
      end else if (byteEnd) begin
        ackPhase_ff <= 1'b1;
        bitCnt_ff <= '0;
        state_ff <= nxt_state;
      end else if (ackEnd) begin
        ackPhase_ff <= 1'b0;
        if (state_ff == ST_RDATA && !mAck_ff) begin
          state_ff <= ST_IDLE;
        end
      end
    end
  end

  // ==========================================================
  // link domain: sda drive and transmit shifter
  always_ff @(posedge linkClk) begin
    if (!linkRstn || startDet || stopDet || state_ff == ST_IDLE) begin
      sdaOe_ff <= 1'b0;
      txShift_ff <= '0;
      txActive_ff <= 1'b0;
    end else if (byteEnd) begin
      sdaOe_ff <= devAck;
    end else if (ackEnd) begin
      if (state_ff == ST_RDATA && mAck_ff) begin
        sdaOe_ff <= !rdData[BYTE_W-1];
        txShift_ff <= rdData;
        txActive_ff <= 1'b1;
      end else begin
        sdaOe_ff <= 1'b0;
      end
    end else if (sclFall && txActive_ff && !ackPhase_ff) begin
      sdaOe_ff <= !txShift_ff[BYTE_W-2];
      txShift_ff <= {txShift_ff[BYTE_W-2:0], 1'b1};
    end
  end

  assign sdaOe = sdaOe_ff;
  assign sdaOut = SDA_DRIVE_LVL;

  // ==========================================================
  // link domain: address pointer and protect strobe
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      adrHi_ff <= '0;
      curAddr_ff <= '0;
      firstData_ff <= 1'b0;
      wpLatched_ff <= 1'b0;
    end else if (startDet || stopDet) begin
      firstData_ff <= 1'b0;
    end else if (byteEnd && state_ff == ST_ADRHI) begin
      adrHi_ff <= rxShift_ff[ADRHI_USED-1:0];
    end else if (byteEnd && state_ff == ST_ADRLO) begin
      curAddr_ff <= {adrHi_ff, rxShift_ff};
      firstData_ff <= 1'b1;
      wpLatched_ff <= 1'b0;
    end else if (ackEnd && firstData_ff) begin
      wpLatched_ff <= wpS;
      firstData_ff <= 1'b0;
    end else if (byteEnd && state_ff == ST_WDATA && !wpLatched_ff) begin
      curAddr_ff[PAGE_W-1:0] <= curAddr_ff[PAGE_W-1:0] + PAGE_W'(1);
    end else if (ackRise && state_ff == ST_RDATA && txActive_ff) begin
      curAddr_ff <= curAddr_ff + ADDR_W'(1);
    end
  end

  // ==========================================================
  // link domain: page buffer and commit
  logic [BYTE_W-1:0] pageBuf_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageMask_ff;
  logic bufWr;

  assign bufWr = byteEnd && state_ff == ST_WDATA && !wpLatched_ff;

  for (genvar g = 0; g < PAGE_BYTES; g++) begin : gBuf
    always_ff @(posedge linkClk) begin
      if (!linkRstn) begin
        pageBuf_ff[g] <= ERASED_BYTE;
        pageMask_ff[g] <= 1'b0;
      end else if (byteEnd && state_ff == ST_ADRLO) begin
        pageMask_ff[g] <= 1'b0;
      end else if (bufWr && curAddr_ff[PAGE_W-1:0] == PAGE_W'(g)) begin
        pageBuf_ff[g] <= rxShift_ff;
        pageMask_ff[g] <= 1'b1;
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      pending_ff <= 1'b0;
      commitBusy_ff <= 1'b0;
      commitIdx_ff <= '0;
      progReqT_ff <= 1'b0;
    end else if (commitBusy_ff) begin
      commitIdx_ff <= commitIdx_ff + PAGE_W'(1);
      commitBusy_ff <= (commitIdx_ff != PAGE_END);
    end else if (stopDet && pending_ff) begin
      pending_ff <= 1'b0;
      commitBusy_ff <= 1'b1;
      commitIdx_ff <= '0;
      progReqT_ff <= ~progReqT_ff;
    end else if (startDet) begin
      pending_ff <= 1'b0;
    end else if (bufWr) begin
      pending_ff <= 1'b1;
    end
  end

  ises_mem #(
    .DATA_W(BYTE_W),
    .ADDR_W(ADDR_W),
    .INIT_VAL(ERASED_BYTE)
  ) uMem (
    .clk(linkClk),
    .wrEn(commitBusy_ff && pageMask_ff[commitIdx_ff]),
    .wrAddr({curAddr_ff[ADDR_W-1:PAGE_W], commitIdx_ff}),
    .wrData(pageBuf_ff[commitIdx_ff]),
    .rdAddr(curAddr_ff),
    .rdData_ff(rdData)
  );

  // ==========================================================
  // link domain checks
  default clocking lcb @(posedge linkClk); endclocking
  default disable iff (!linkRstn);

  sequence seq_commit_run;
    commitBusy_ff [*8] ##24 commitBusy_ff ##1 !commitBusy_ff;
  endsequence

  busy_nack_a: assert property (
    byteEnd && state_ff == ST_DEVADDR && !linkReady |=> !sdaOe)
    else $error("acked while busy or not ready");

  stop_end_a: assert property (
    stopDet |=> state_ff == ST_IDLE && !sdaOe)
    else $error("stop did not end the session");

  idle_quiet_a: assert property (
    state_ff == ST_IDLE && !startDet |=> state_ff == ST_IDLE && !sdaOe)
    else $error("bus answered without a start");

  drive_edge_a: assert property (
    $rose(sdaOe) |-> $past(sclFall))
    else $error("sda driven away from scl fall");

  prefix_miss_a: assert property (
    byteEnd && state_ff == ST_DEVADDR &&
    rxShift_ff[PREFIX_HI:PREFIX_LO] != DEV_PREFIX
    |=> state_ff == ST_IDLE && !sdaOe)
    else $error("foreign address acknowledged");

  addr_ack_a: assert property (
    byteEnd && (state_ff == ST_ADRHI || state_ff == ST_ADRLO)
    |=> sdaOe && ackPhase_ff)
    else $error("address byte not acknowledged");

  wp_nack_a: assert property (
    byteEnd && state_ff == ST_WDATA && wpLatched_ff
    |=> !sdaOe ##0 state_ff == ST_IDLE)
    else $error("protected data byte acknowledged");

  page_hold_a: assert property (
    bufWr |=> curAddr_ff[ADDR_W-1:PAGE_W] ==
      $past(curAddr_ff[ADDR_W-1:PAGE_W]))
    else $error("page bits moved during page load");

  read_step_a: assert property (
    ackRise && state_ff == ST_RDATA && txActive_ff
    |=> curAddr_ff == $past(curAddr_ff) + ADDR_W'(1))
    else $error("read address did not advance");

  commit_span_a: assert property (
    $rose(commitBusy_ff) |-> seq_commit_run)
    else $error("page commit length wrong");

endmodule : ises_top

// ---- testbench/ises_master_model.sv ----
// Purpose: bus master model driving the two-wire lines of the slave
// Assumes: pull-up on sda, timing counted in link clock cycles
// Notes: scl stands high between frames, sda released when idle
`timescale 1ns/100ps
module ises_master_model (
  input wire logic linkClk,
  input wire logic devOe,
  output logic scl,
  output logic sda
);
  logic mOe;
  // ====================
  // wire resolution
  assign sda = (mOe || devOe) ? 1'b0 : 1'b1;
  initial begin
    scl = 1'b1;
    mOe = 1'b0;
  end
  // ====================
  // bus conditions
  task automatic lk(input int n);
    repeat (n) @(posedge linkClk);
  endtask : lk
  // also serves as repeated start; sda released before scl is raised
  task automatic start_c();
    mOe <= 1'b0;
    lk(6);
    scl <= 1'b1;
    lk(6);
    mOe <= 1'b1;
    lk(6);
    scl <= 1'b0;
    lk(6);
  endtask : start_c
  task automatic stop_c();
    mOe <= 1'b1;
    lk(6);
    scl <= 1'b1;
    lk(6);
    mOe <= 1'b0;
    lk(12);
  endtask : stop_c
  // sda set while scl low, held through the high phase
  task automatic bit_x(input logic b, output logic r);
    mOe <= !b;
    lk(6);
    scl <= 1'b1;
    lk(3);
    @(negedge linkClk);
    r = sda;
    lk(3);
    scl <= 1'b0;
  endtask : bit_x
  // ====================
  // byte transfers, ninth bit released or acked
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(!mack, r);
  endtask : rbyte
endmodule : ises_master_model

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the serial eeprom slave
// Assumes: master model on the bus, shortened program and ready counts
// Notes: strap pins tied to one setting
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) begin \
      errCount++; \
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb;
  import ises_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic resetn = 1'b0;
  logic writeProtect = 1'b0;
  logic scl, sda, sdaOut, sdaOe, writeCycleBusy;
  logic busyPrev_ff = 1'b0;
  int busyRises = 0;
  int errCount = 0;
  int checksDone = 0;
  // ====================
  // clocks and instances
  always #5 clk = ~clk;
  initial begin
    #7;
    forever #15 linkClk = ~linkClk;
  end
  always @(posedge clk) begin
    busyPrev_ff <= writeCycleBusy;
    if (writeCycleBusy === 1'b1 && busyPrev_ff === 1'b0) busyRises++;
  end
  ises_top #(.PROG_CYCLES(600), .READY_CYCLES(20)) DUT (
    .clk(clk), .resetn(resetn), .linkClk(linkClk), .scl(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .strapSelBit0(STRAP[0]), .strapSelBit1(STRAP[1]),
    .strapSelBit2(STRAP[2]), .writeProtect(writeProtect),
    .writeCycleBusy(writeCycleBusy));
  ises_master_model M (.linkClk(linkClk), .devOe(sdaOe), .scl(scl),
    .sda(sda));
  // ====================
  // helpers
  task automatic hdr(input logic [3:0] pre, input logic [2:0] st,
      input logic rw, output logic ack);
    M.start_c();
    M.wbyte({pre, st, rw}, ack);
  endtask : hdr
  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic a;
    hdr(DEV_PREFIX, STRAP, 1'b0, a);
    `CHK("header ack", 1'b1, a)
    M.wbyte(hi, a);
    `CHK("addr hi ack", 1'b1, a)
    M.wbyte(lo, a);
    `CHK("addr lo ack", 1'b1, a)
  endtask : set_addr
  task automatic rd_chk(input logic [7:0] hi, input logic [7:0] lo,
      input logic [7:0] e0, input logic [7:0] e1);
    logic a;
    logic [7:0] d;
    set_addr(hi, lo);
    hdr(DEV_PREFIX, STRAP, 1'b1, a);
    `CHK("read header ack", 1'b1, a)
    M.rbyte(1'b1, d);
    `CHK("read byte 0", e0, d)
    M.rbyte(1'b0, d);
    `CHK("read byte 1", e1, d)
    M.stop_c();
  endtask : rd_chk
  task automatic wait_ready(output int tries);
    logic a;
    tries = 0;
    a = 1'b0;
    while (!a && tries < 20) begin
      tries++;
      hdr(DEV_PREFIX, STRAP, 1'b0, a);
      M.stop_c();
    end
    `CHK("device ready", 1'b1, a)
  endtask : wait_ready
  // ====================
  // scenarios
  task automatic t_reset();
    int n;
    repeat (12) @(posedge clk);
    `CHK("oe in reset", 1'b0, sdaOe)
    `CHK("busy in reset", 1'b0, writeCycleBusy)
    `CHK("open drain level", 1'b0, sdaOut)
    resetn <= 1'b1;
    wait_ready(n);
  endtask : t_reset
  task automatic t_address();
    logic a;
    for (int i = 0; i < 3; i++) begin
      hdr(DEV_PREFIX, STRAP ^ (3'h1 << i), 1'b0, a);
      M.stop_c();
      `CHK("strap mismatch", 1'b0, a)
    end
    hdr(4'hb, STRAP, 1'b0, a);
    M.stop_c();
    `CHK("prefix mismatch", 1'b0, a)
    M.wbyte({DEV_PREFIX, STRAP, 1'b0}, a);
    M.stop_c();
    `CHK("no start", 1'b0, a)
  endtask : t_address
  task automatic t_page();
    logic a;
    logic [7:0] d;
    logic [7:0] pg [4];
    int n;
    int r0;
    pg = '{8'h11, 8'h22, 8'h33, 8'h44};
    set_addr(8'h20, 8'h1e);
    for (int i = 0; i < 4; i++) begin
      M.wbyte(pg[i], a);
      `CHK("data ack", 1'b1, a)
    end
    r0 = busyRises;
    M.stop_c();
    wait_ready(n);
    `CHK("poll refused while busy", 1'b1, n > 1)
    `CHK("program cycles", r0 + 1, busyRises)
    rd_chk(8'h00, 8'h1e, 8'h11, 8'h22);
    rd_chk(8'h1f, 8'hff, 8'hff, 8'h33);
    hdr(DEV_PREFIX, STRAP, 1'b1, a);
    `CHK("immediate ack", 1'b1, a)
    M.rbyte(1'b0, d);
    `CHK("immediate data", 8'h44, d)
    M.stop_c();
  endtask : t_page
  task automatic t_protect();
    logic a;
    int r0;
    r0 = busyRises;
    @(posedge clk) writeProtect <= 1'b1;
    set_addr(8'h00, 8'h1e);
    M.wbyte(8'h99, a);
    `CHK("protected data nack", 1'b0, a)
    M.stop_c();
    @(posedge clk) writeProtect <= 1'b0;
    set_addr(8'h00, 8'h1e);
    M.wbyte(8'h55, a);
    `CHK("unprotected data ack", 1'b1, a)
    for (int i = 0; i < 4; i++) begin
      M.bit_x(1'b0, a);
    end
    M.start_c();
    M.stop_c();
    repeat (300) @(posedge clk);
    `CHK("no program cycle", r0, busyRises)
    rd_chk(8'h00, 8'h1e, 8'h11, 8'h22);
  endtask : t_protect
  // supply dip in a loaded page: nothing may be programmed
  task automatic t_brownout();
    logic a;
    int n;
    int r0;
    r0 = busyRises;
    set_addr(8'h00, 8'h1e);
    M.wbyte(8'h77, a);
    `CHK("loaded data ack", 1'b1, a)
    @(posedge clk) resetn <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("oe in brownout", 1'b0, sdaOe)
    `CHK("busy in brownout", 1'b0, writeCycleBusy)
    resetn <= 1'b1;
    M.stop_c();
    wait_ready(n);
    `CHK("no program after brownout", r0, busyRises)
    rd_chk(8'h00, 8'h1e, 8'h11, 8'h22);
  endtask : t_brownout
  // ====================
  // run control
  task automatic printVerdict();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : printVerdict
  initial begin
    t_reset();
    t_address();
    t_page();
    t_protect();
    t_brownout();
    printVerdict();
  end
  initial begin
    #900000;
    errCount++;
    printVerdict();
  end
endmodule : tb
